// ===== rtl/rw_alu_pkg.sv
// Shared constants and types of the byte register ALU datapath
package rw_alu_pkg;

   // ------------------------------------------------------------
   // Instruction word layout
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] itype;
      logic [2:0] opcode;
      logic [2:0] operator_sel;
      logic use_acc;
      logic [6:0] reg_addr;
      logic [7:0] immediate_byte;
      logic [7:0] unused;
   } rw_word_t;

   localparam logic [1:0] ITYPE_RW = 2'h1;
   localparam logic [2:0] OPC_RMW = 3'h7;
   localparam logic [2:0] OPC_TO_ACC = 3'h6;
   localparam logic [2:0] OPC_FROM_ACC = 3'h5;
   localparam logic [2:0] OPR_LOAD = 3'h0;
   localparam logic [2:0] OPR_SHIFT_LEFT = 3'h1;
   localparam logic [2:0] OPR_OR = 3'h2;
   localparam logic [2:0] OPR_XOR = 3'h3;
   localparam logic [2:0] OPR_AND = 3'h4;

   // ------------------------------------------------------------
   // Register port map
   // ------------------------------------------------------------
   localparam int REG_COUNT = 128;
   localparam logic [7:0] ADDR_ACC = 8'h80;
   localparam logic [7:0] ADDR_STATUS = 8'h81;
   localparam logic [7:0] ADDR_CTRL = 8'h82;
   localparam logic [7:0] ADDR_COUNT = 8'h83;
   localparam logic [7:0] ADDR_RESULT = 8'h84;
   localparam int ST_CARRY_BIT = 0;
   localparam int ST_BUSY_BIT = 1;
   localparam int ST_ILLEGAL_BIT = 2;
   localparam int CTL_ENABLE_BIT = 0;
   localparam logic [7:0] CHIP_REG_RESET = 8'h00;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h01;
   localparam logic [7:0] COUNT_RESET = 8'h00;

   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_WRITE = 2'b11
   } alu_state_t;

endpackage : rw_alu_pkg

// ===== rtl/byte_alu_core.sv
// Combinational byte operator unit with carry
`timescale 1ns/1ps
`default_nettype none
module byte_alu_core
   import rw_alu_pkg::*;
(
   input wire logic [2:0] operator_i,
   input wire logic [7:0] src_i,
   input wire logic [7:0] operand_i,
   input wire logic carry_i,
   output logic [7:0] result_o,
   output logic carry_o,
   output logic known_o
);

   always_comb begin
      result_o = src_i;
      carry_o = carry_i;
      known_o = 1'b1;
      case (operator_i)
         OPR_LOAD: begin
            result_o = operand_i;
         end
         OPR_SHIFT_LEFT: begin
            result_o = {src_i[6:0], carry_i};
            carry_o = src_i[7];
         end
         OPR_OR: begin
            result_o = src_i | operand_i;
         end
         OPR_XOR: begin
            result_o = src_i ^ operand_i;
         end
         OPR_AND: begin
            result_o = src_i & operand_i;
         end
         default: begin
            // Right shift and add forms are not provided here; they are flagged as unknown
            known_o = 1'b0;
         end
      endcase
   end

endmodule : byte_alu_core
`default_nettype wire

// ===== rtl/chip_reg_array.sv
// Array of byte-wide chip registers, two write and two read ports
`timescale 1ns/1ps
`default_nettype none
module chip_reg_array
   import rw_alu_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sw_we_i,
   input wire logic [6:0] sw_addr_i,
   input wire logic [7:0] sw_data_i,
   input wire logic alu_we_i,
   input wire logic [6:0] alu_addr_i,
   input wire logic [7:0] alu_data_i,
   input wire logic [6:0] sw_raddr_i,
   input wire logic [6:0] alu_raddr_i,
   output logic [7:0] sw_rdata_o,
   output logic [7:0] alu_rdata_o
);

   logic [7:0] mem_q [REG_COUNT];

   genvar g;
   generate
      for (g = 0; g < REG_COUNT; g++) begin : g_entry
         wire sw_hit = sw_we_i && (sw_addr_i == 7'(g));
         wire alu_hit = alu_we_i && (alu_addr_i == 7'(g));
         // The datapath write wins a same-cycle clash
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               mem_q[g] <= CHIP_REG_RESET;
            end else if (alu_hit) begin
               mem_q[g] <= alu_data_i;
            end else if (sw_hit) begin
               mem_q[g] <= sw_data_i;
            end
         end
      end
   endgenerate

   assign sw_rdata_o = mem_q[sw_raddr_i];
   assign alu_rdata_o = mem_q[alu_raddr_i];

endmodule : chip_reg_array
`default_nettype wire

// ===== rtl/byte_register_alu_ops.sv
// Byte register read/write ALU datapath of the script processor
//
// Behaviour
// - Each instruction touches at most two registers: the accumulator and the addressed register.
// - Any chip register can be moved into or out of the accumulator.
// - Op code 111 reads the addressed register, operates with the immediate and writes it back.
// - Op code 110 operates on the addressed register and writes only the accumulator.
// - Op code 101 operates on the accumulator and writes the addressed register.
// - Operator 000 loads the immediate byte unchanged into the destination.
// - Operator 001 shifts the source left by one and stores it in the destination.
// - Operator 010 stores source OR immediate in the destination.
// - Operator 011 stores source XOR immediate in the destination.
// - Operator 100 stores source AND immediate in the destination.
// - Shifts pass through carry: the old carry fills bit 0, bit 7 goes to carry.
// - Bit 23 set makes the accumulator replace the immediate as second operand.
// - Bits 22 to 16 select the addressed byte register.
// - Bits 15 to 8 carry the immediate byte.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module byte_register_alu_ops
   import rw_alu_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_I,
   // Sequencer side
   input wire logic INSTR_VALID_I,
   input wire logic [31:0] INSTR_I,
   output logic READY_O,
   output logic DONE_O,
   output logic ILLEGAL_O,
   output logic CARRY_O,
   output logic [7:0] ACC_O,
   output logic [7:0] RESULT_O,
   // Register port
   input wire logic [7:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   alu_state_t state_q;
   alu_state_t state_d;
   rw_word_t instr_q;
   logic [7:0] src_q;
   logic [7:0] acc_q;
   logic [7:0] acc_d;
   logic carry_q;
   logic carry_d;
   logic illegal_q;
   logic enable_q;
   logic [7:0] count_q;
   logic [7:0] result_q;
   logic ready_q;
   logic done_q;
   logic illegal_pulse_q;
   logic [7:0] rdata_q;

   // ------------------------------------------------------------
   // Instruction decode
   // ------------------------------------------------------------
   rw_word_t word_in;
   wire take;
   wire kind_ok;
   wire opc_rmw;
   wire opc_to_acc;
   wire opc_from_acc;
   wire [7:0] second_operand;
   wire [7:0] fetched;

   assign word_in = rw_word_t'(INSTR_I);
   assign take = INSTR_VALID_I && ready_q;
   assign opc_rmw = (instr_q.opcode == OPC_RMW);
   assign opc_to_acc = (instr_q.opcode == OPC_TO_ACC);
   assign opc_from_acc = (instr_q.opcode == OPC_FROM_ACC);
   assign kind_ok = (instr_q.itype == ITYPE_RW)
      && (opc_rmw || opc_to_acc || opc_from_acc);

   // Accumulator steps in for the immediate
   assign second_operand = instr_q.use_acc ? acc_q
      : instr_q.immediate_byte;

   // ------------------------------------------------------------
   // Register port decode
   // ------------------------------------------------------------
   wire sw_chip;
   wire sw_wr_chip;
   wire sw_wr_acc;
   wire sw_wr_status;
   wire sw_wr_ctrl;
   wire sw_wr_count;
   wire [7:0] chip_rdata;
   wire [7:0] status_word;
   wire [7:0] ctrl_word;
   wire [7:0] rd_mux;

   assign sw_chip = (ADDR_I[7] == 1'b0);
   assign sw_wr_chip = WR_I && sw_chip;
   assign sw_wr_acc = WR_I && (ADDR_I == ADDR_ACC);
   assign sw_wr_status = WR_I && (ADDR_I == ADDR_STATUS);
   assign sw_wr_ctrl = WR_I && (ADDR_I == ADDR_CTRL);
   assign sw_wr_count = WR_I && (ADDR_I == ADDR_COUNT);

   // Each flag widened before its shift so no bit falls off the top
   assign status_word = ({7'h00, carry_q} << ST_CARRY_BIT)
      | ({7'h00, (state_q != ST_IDLE)} << ST_BUSY_BIT)
      | ({7'h00, illegal_q} << ST_ILLEGAL_BIT);
   assign ctrl_word = {7'h00, enable_q} << CTL_ENABLE_BIT;

   assign rd_mux = sw_chip ? chip_rdata
      : (ADDR_I == ADDR_ACC) ? acc_q
      : (ADDR_I == ADDR_STATUS) ? status_word
      : (ADDR_I == ADDR_CTRL) ? ctrl_word
      : (ADDR_I == ADDR_COUNT) ? count_q
      : (ADDR_I == ADDR_RESULT) ? result_q
      : 8'h00;

   // ------------------------------------------------------------
   // Operator unit
   // ------------------------------------------------------------
   wire [7:0] alu_result;
   wire alu_carry;
   wire alu_known;
   wire exec_ok;
   wire write_chip;
   wire write_acc;

   byte_alu_core u_alu (
      .operator_i(instr_q.operator_sel),
      .src_i(src_q),
      .operand_i(second_operand),
      .carry_i(carry_q),
      .result_o(alu_result),
      .carry_o(alu_carry),
      .known_o(alu_known)
   );

   assign exec_ok = (state_q == ST_WRITE) && kind_ok && alu_known;
   // Destination is either the chip register or the accumulator
   assign write_chip = exec_ok && !opc_to_acc;
   assign write_acc = exec_ok && opc_to_acc;

   // ------------------------------------------------------------
   // Chip registers
   // ------------------------------------------------------------
   chip_reg_array u_regs (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .sw_we_i(sw_wr_chip),
      .sw_addr_i(ADDR_I[6:0]),
      .sw_data_i(WDATA_I),
      .alu_we_i(write_chip),
      .alu_addr_i(instr_q.reg_addr),
      .alu_data_i(alu_result),
      .sw_raddr_i(ADDR_I[6:0]),
      .alu_raddr_i(instr_q.reg_addr),
      .sw_rdata_o(chip_rdata),
      .alu_rdata_o(fetched)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (take) begin
               state_d = ST_FETCH;
            end
         end
         ST_FETCH: begin
            state_d = ST_WRITE;
         end
         ST_WRITE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         instr_q <= '0;
      end else if (take) begin
         instr_q <= word_in;
      end
   end

   // Source is the accumulator only for the move-out form
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         src_q <= 8'h00;
      end else if (state_q == ST_FETCH) begin
         src_q <= opc_from_acc ? acc_q : fetched;
      end
   end

   // ------------------------------------------------------------
   // Accumulator and carry
   // ------------------------------------------------------------
   // Datapath result beats a software write in the same cycle
   always_comb begin
      acc_d = acc_q;
      if (write_acc) begin
         acc_d = alu_result;
      end else if (sw_wr_acc) begin
         acc_d = WDATA_I;
      end
   end

   always_comb begin
      carry_d = carry_q;
      if (exec_ok) begin
         carry_d = alu_carry;
      end else if (sw_wr_status) begin
         carry_d = WDATA_I[ST_CARRY_BIT];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         acc_q <= ACC_RESET;
         carry_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         carry_q <= carry_d;
      end
   end

   // ------------------------------------------------------------
   // Status, control and counters
   // ------------------------------------------------------------
   wire illegal_event;
   wire illegal_clear;

   assign illegal_event = (state_q == ST_WRITE) && !exec_ok;
   assign illegal_clear = sw_wr_status && WDATA_I[ST_ILLEGAL_BIT];

   // New event wins over a clear in the same cycle
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         illegal_q <= 1'b0;
      end else if (illegal_event) begin
         illegal_q <= 1'b1;
      end else if (illegal_clear) begin
         illegal_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         enable_q <= CTRL_RESET[CTL_ENABLE_BIT];
      end else if (sw_wr_ctrl) begin
         enable_q <= WDATA_I[CTL_ENABLE_BIT];
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         count_q <= COUNT_RESET;
      end else if (exec_ok) begin
         count_q <= count_q + 8'h01;
      end else if (sw_wr_count) begin
         count_q <= WDATA_I;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         result_q <= 8'h00;
      end else if (exec_ok) begin
         result_q <= alu_result;
      end
   end

   // ------------------------------------------------------------
   // Handshake outputs
   // ------------------------------------------------------------
   // Ready drops on the taking edge so a held valid is taken once
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         ready_q <= 1'b0;
         done_q <= 1'b0;
         illegal_pulse_q <= 1'b0;
      end else begin
         ready_q <= (state_d == ST_IDLE) && !take
            && (sw_wr_ctrl ? WDATA_I[CTL_ENABLE_BIT] : enable_q);
         done_q <= exec_ok;
         illegal_pulse_q <= illegal_event;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         rdata_q <= 8'h00;
      end else if (RD_I) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign READY_O = ready_q;
   assign DONE_O = done_q;
   assign ILLEGAL_O = illegal_pulse_q;
   assign CARRY_O = carry_q;
   assign ACC_O = acc_q;
   assign RESULT_O = result_q;
   assign RDATA_O = rdata_q;

endmodule : byte_register_alu_ops
`default_nettype wire

// ===== testbench/byte_register_alu_ops_chk.sv
// Assertion checker for the byte register ALU datapath
`timescale 1ns/1ps
`default_nettype none
module byte_register_alu_ops_chk
   import rw_alu_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic INSTR_VALID_I,
   input wire logic [31:0] INSTR_I,
   input wire logic READY_O,
   input wire logic DONE_O,
   input wire logic ILLEGAL_O,
   input wire logic CARRY_O,
   input wire logic [7:0] ACC_O,
   input wire logic [7:0] RESULT_O
);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (RST_I);
   wire take = INSTR_VALID_I && READY_O;
   wire rw = INSTR_I[31:30] == ITYPE_RW;
   wire [2:0] opc = INSTR_I[29:27];
   wire [2:0] opr = INSTR_I[26:24];
   logic [7:0] acc_q;
   logic [7:0] imm_q;
   logic carry_q;
   // Operands as offered; no software writes land mid-instruction
   always_ff @(posedge CLK_I) begin
      if (take) begin
         acc_q <= ACC_O;
         imm_q <= INSTR_I[15:8];
         carry_q <= CARRY_O;
      end
   end
   sequence s_take(c);
      take && c;
   endsequence
   sequence s_done;
      ##3 (DONE_O && !ILLEGAL_O);
   endsequence
   sequence s_bad;
      ##3 (ILLEGAL_O && !DONE_O);
   endsequence
   AST_ANSWER: assert property (s_take(1'b1) |->
      ##3 (DONE_O ^ ILLEGAL_O))
      else $error("no answer three edges after take");
   AST_BUSY: assert property (take |=> !READY_O [*2])
      else $error("ready during execution");
   AST_BAD_OPC: assert property (
      s_take(rw && opc < OPC_FROM_ACC) |-> s_bad)
      else $error("bad op code not refused");
   AST_LOAD_ACC: assert property (s_take(rw && opc == OPC_TO_ACC &&
      opr == OPR_LOAD && !INSTR_I[23]) |-> s_done ##0 ACC_O == imm_q)
      else $error("load to accumulator wrong");
   AST_ACC_KEPT: assert property (s_take(opc != OPC_TO_ACC) |->
      ##3 $stable(ACC_O))
      else $error("accumulator changed");
   AST_CARRY_KEPT: assert property (
      s_take(opr != OPR_SHIFT_LEFT) |-> ##3 $stable(CARRY_O))
      else $error("carry changed without shift");
   AST_SHIFT: assert property (s_take(rw && opc == OPC_FROM_ACC &&
      opr == OPR_SHIFT_LEFT) |-> s_done ##0 (CARRY_O == acc_q[7] &&
      RESULT_O == {acc_q[6:0], carry_q}))
      else $error("shift through carry wrong");
   AST_OR_ACC: assert property (s_take(rw && opc == OPC_FROM_ACC &&
      opr == OPR_OR && !INSTR_I[23]) |->
      s_done ##0 RESULT_O == (acc_q | imm_q))
      else $error("or from accumulator wrong");
   AST_USE_ACC: assert property (s_take(rw && opc == OPC_FROM_ACC &&
      opr == OPR_XOR && INSTR_I[23]) |-> s_done ##0 RESULT_O == 8'h00)
      else $error("accumulator not used as operand");
endmodule : byte_register_alu_ops_chk
bind byte_register_alu_ops byte_register_alu_ops_chk chk (
   .CLK_I(CLK_I), .RST_I(RST_I), .INSTR_VALID_I(INSTR_VALID_I),
   .INSTR_I(INSTR_I), .READY_O(READY_O), .DONE_O(DONE_O),
   .ILLEGAL_O(ILLEGAL_O), .CARRY_O(CARRY_O), .ACC_O(ACC_O),
   .RESULT_O(RESULT_O));
`default_nettype wire

// ===== testbench/instr_seq_model.sv
// Sequencer model that offers decoded instruction words
`timescale 1ns/1ps
`default_nettype none
module instr_seq_model (
   input wire logic clk_i,
   input wire logic ready_i,
   output logic valid_o,
   output logic [31:0] instr_o
);
   int waits;
   initial begin
      valid_o = 1'b0;
      instr_o = 32'h0000_0000;
   end
   // Word held until taken or 64 edges pass, then inverted so a late sample cannot pass
   task automatic issue(input logic [31:0] w);
      waits = 0;
      valid_o <= 1'b1;
      instr_o <= w;
      do begin
         @(posedge clk_i);
         waits++;
      end while (!ready_i && waits < 64);
      valid_o <= 1'b0;
      instr_o <= ~w;
   endtask : issue
endmodule : instr_seq_model
`default_nettype wire

// ===== testbench/tb_byte_register_alu_ops.sv
// Self-checking bench for the byte register ALU datapath
`timescale 1ns/1ps
`default_nettype none
module tb_byte_register_alu_ops
   import rw_alu_pkg::*;
   ;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic valid, ready, done, illegal, carry, wr = 1'b0, rd = 1'b0;
   logic [31:0] instr;
   logic [7:0] acc, result, rdata, addr = 8'h00, wdata = 8'h00;
   logic [7:0] v, s, b, rv, av;
   logic [8:0] r;
   logic [6:0] a;
   logic [2:0] opc;
   int err_total = 0, num_checks = 0, cyc = 0;
   always #2 clk = ~clk;
   byte_register_alu_ops dut (
      .CLK_I(clk), .RST_I(rst), .INSTR_VALID_I(valid), .INSTR_I(instr),
      .READY_O(ready), .DONE_O(done), .ILLEGAL_O(illegal),
      .CARRY_O(carry), .ACC_O(acc), .RESULT_O(result), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
   instr_seq_model seq (.clk_i(clk), .ready_i(ready), .valid_o(valid),
      .instr_o(instr));
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string n, input logic [7:0] e,
         input logic [7:0] x);
      num_checks++;
      if (x !== e) begin
         $display("BAD %s exp %h got %h", n, e, x);
         err_total++;
      end
   endtask : chk
   task automatic wrb(input logic [7:0] ad, input logic [7:0] d);
      wr <= 1'b1;
      addr <= ad;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : wrb
   task automatic rdb(input logic [7:0] ad, output logic [7:0] d);
      rd <= 1'b1;
      addr <= ad;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask : rdb
   task automatic exw(input logic [31:0] w, input logic dn);
      seq.issue(w);
      repeat (3) @(posedge clk);
      chk("done", {7'h00, dn}, {7'h00, done});
      chk("illegal", {7'h00, !dn}, {7'h00, illegal});
   endtask : exw
   function automatic logic [8:0] alu(input logic [2:0] o,
         input logic [7:0] x, input logic [7:0] y, input logic c);
      case (o)
         OPR_LOAD: alu = {c, y};
         OPR_SHIFT_LEFT: alu = {x[7], x[6:0], c};
         OPR_OR: alu = {c, x | y};
         OPR_XOR: alu = {c, x ^ y};
         default: alu = {c, x & y};
      endcase
   endfunction : alu
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         conclude();
      end
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdb(ADDR_ACC, v);
      chk("acc reset", ACC_RESET, v);
      rdb(ADDR_CTRL, v);
      chk("ctrl reset", CTRL_RESET, v);
      rdb(8'h7F, v);
      chk("reg reset", CHIP_REG_RESET, v);
      wrb(8'h90, 8'hFF);
      rdb(8'h90, v);
      chk("unmapped", 8'h00, v);
      $display("reset test end");
      for (int u = 0; u < 2; u++) begin
         for (int k = 0; k < 3; k++) begin
            for (int o = 0; o < 5; o++) begin
               opc = OPC_RMW - 3'(k);
               a = 7'h7F - 7'(u * 15 + k * 5 + o);
               rv = 8'hB4 ^ {1'b0, a};
               av = 8'h5A ^ 8'(o);
               wrb({1'b0, a}, rv);
               wrb(ADDR_ACC, av);
               wrb(ADDR_STATUS, {7'h00, a[0]});
               s = (opc == OPC_FROM_ACC) ? av : rv;
               b = u ? av : 8'h3C;
               r = alu(3'(o), s, b, a[0]);
               exw({ITYPE_RW, opc, 3'(o), u[0], a, 8'h3C, 8'h00}, 1'b1);
               chk("result pin", r[7:0], result);
               chk("acc pin", (opc == OPC_TO_ACC) ? r[7:0] : av, acc);
               chk("carry pin", {7'h00, r[8]}, {7'h00, carry});
               rdb({1'b0, a}, v);
               chk("reg", (opc == OPC_TO_ACC) ? rv : r[7:0], v);
               rdb(ADDR_ACC, v);
               chk("acc", (opc == OPC_TO_ACC) ? r[7:0] : av, v);
               rdb(ADDR_STATUS, v);
               chk("carry", {7'h00, r[8]}, v & 8'h01);
            end
         end
      end
      $display("operator table end");
      rdb(ADDR_COUNT, v);
      chk("count", 8'h1E, v);
      wrb(ADDR_COUNT, 8'hFE);
      wrb(8'h00, 8'hE7);
      wrb(8'h41, 8'h18);
      exw({ITYPE_RW, OPC_TO_ACC, OPR_OR, 1'b0, 7'h00, 16'h0000}, 1'b1);
      exw({ITYPE_RW, OPC_FROM_ACC, OPR_OR, 1'b0, 7'h41, 16'h0000}, 1'b1);
      rdb(8'h41, v);
      chk("copy", 8'hE7, v);
      rdb(ADDR_RESULT, v);
      chk("result reg", 8'hE7, v);
      rdb(ADDR_COUNT, v);
      chk("count wrap", 8'h00, v);
      $display("copy test end");
      wrb(8'h10, 8'h77);
      exw({2'b00, OPC_RMW, OPR_LOAD, 1'b0, 7'h10, 16'h0000}, 1'b0);
      exw({ITYPE_RW, 3'h4, OPR_LOAD, 1'b0, 7'h10, 16'h0000}, 1'b0);
      exw({ITYPE_RW, OPC_RMW, 3'h5, 1'b0, 7'h10, 16'h0000}, 1'b0);
      rdb(8'h10, v);
      chk("kept", 8'h77, v);
      rdb(ADDR_STATUS, v);
      chk("illegal flag", 8'h04, v & 8'h04);
      wrb(ADDR_STATUS, 8'h04);
      rdb(ADDR_STATUS, v);
      chk("illegal clear", 8'h00, v & 8'h04);
      wrb(ADDR_CTRL, 8'h00);
      chk("ready off", 8'h00, {7'h00, ready});
      $display("refusal test end");
      conclude();
   end
endmodule : tb_byte_register_alu_ops
`default_nettype wire
